/* core/status_flags_pkg.sv */
// Package: register map, field positions, timing and carriers for the metering status flag bank.
// Assumes a single 100 MHz core clock and that metrology conditions arrive from logic on that clock.
package status_flags_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Register offsets and reset value.
    localparam logic [15:0] AUTOCAL_STATUS_ADDR = 16'h04c0;
    localparam logic [15:0] EVENT_LEVELS_ADDR   = 16'h04c1;
    localparam logic [15:0] CHIP_ERROR_ADDR     = 16'h04c2;
    localparam logic [15:0] REG_RESET_VALUE     = 16'h0000;

    // Field positions in the autocalibration status register.
    localparam int AUTOCAL_TIMEOUT_BIT = 3;
    localparam int AUTOCAL_READY_BIT   = 1;
    localparam int COEF_SHIFT_BIT      = 0;

    // Field positions in the event register.
    localparam int OVERCURRENT_B_BIT = 5;
    localparam int OVERCURRENT_A_BIT = 4;
    localparam int SWELL_BIT         = 2;
    localparam int DIP_BIT           = 0;

    // Field positions in the chip error register.
    localparam int SERIAL_RESET_BIT  = 7;
    localparam int SERIAL_FAULT_LSB  = 4;
    localparam int INTERNAL_FAULT_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Timing: clock period, one second, autocalibration limits.
    localparam int CLK_PERIOD_NS       = 10;
    localparam int ONE_SEC_NS          = 1000000000;
    localparam int CYCLES_PER_SEC      = ONE_SEC_NS / CLK_PERIOD_NS;
    localparam int AUTOCAL_TIMEOUT_SEC = 600;
    localparam int FIRST_BLOCK_SEC     = 8;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Carriers for grouped condition inputs.
    typedef struct packed {
        logic overcurrent_chan_b;
        logic overcurrent_chan_a;
        logic voltage_swell_level;
        logic voltage_dip_level;
    } event_levels_type;

    typedef struct packed {
        logic serial_fault_2;
        logic serial_fault_1;
        logic serial_fault_0;
    } serial_faults_type;

    typedef struct packed {
        logic internal_fault_3;
        logic internal_fault_2;
        logic internal_fault_1;
        logic internal_fault_0;
    } internal_faults_type;

endpackage

/* core/autocal_timer.sv */
// Autocalibration run timer: one-second ticks, first result after the accumulation block, timeout.
// Assumes run_active is a level from logic on core_clk.
`timescale 1ns/10ps
module autocal_timer #(
    parameter int CYCLES_PER_SEC = status_flags_pkg::CYCLES_PER_SEC // Clock cycles in one second.
) (
    input  wire logic core_clk,      // Core clock, 100 MHz.
    input  wire logic sys_rst,       // Synchronous reset, active high.
    input  wire logic run_active,    // Autocalibration run is enabled.
    output logic      result_pulse,  // One-cycle pulse per result update.
    output logic      timeout_pulse, // One-cycle pulse when the run times out.
    output logic      first_result   // High while result_pulse is the first of the run.
);

    typedef enum logic [1:0] {IDLE, RUNNING, EXPIRED} timer_state_type;

    timer_state_type state;
    logic [31:0]     cycle_cnt;
    logic [9:0]      sec_cnt;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Decode of the second boundary and of the elapsed-second milestones.
    wire       sec_tick     = (state == RUNNING) && (cycle_cnt == 32'(CYCLES_PER_SEC - 1));
    wire [9:0] next_sec_cnt = sec_cnt + 10'h001;
    wire       hit_timeout  = sec_tick && (next_sec_cnt == 10'(status_flags_pkg::AUTOCAL_TIMEOUT_SEC));
    wire       hit_result   = sec_tick && !hit_timeout &&
                              (next_sec_cnt >= 10'(status_flags_pkg::FIRST_BLOCK_SEC));

    // Run sequencing; stopping the run at any time returns to idle so that no stale tick leaks out.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !run_active)
        begin
            state         <= IDLE;
            cycle_cnt     <= 32'h0000_0000;
            sec_cnt       <= 10'h000;
            result_pulse  <= 1'b0;
            timeout_pulse <= 1'b0;
            first_result  <= 1'b0;
        end
        else
        begin
            result_pulse  <= hit_result;
            timeout_pulse <= hit_timeout;
            first_result  <= hit_result && (next_sec_cnt == 10'(status_flags_pkg::FIRST_BLOCK_SEC));
            unique case (state)
                IDLE:
                begin
                    state <= RUNNING;
                end
                RUNNING:
                begin
                    cycle_cnt <= sec_tick ? 32'h0000_0000 : cycle_cnt + 32'h0000_0001;
                    if (sec_tick)
                    begin
                        sec_cnt <= next_sec_cnt;
                    end
                    if (hit_timeout)
                    begin
                        state <= EXPIRED;
                    end
                end
                EXPIRED:
                begin
                    state <= EXPIRED;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks on the run timer.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_timeout_at_limit;
        timeout_pulse |-> sec_cnt == 10'(status_flags_pkg::AUTOCAL_TIMEOUT_SEC) && state == EXPIRED;
    endproperty
    a_timeout_at_limit: assert property (p_timeout_at_limit)
        else $error("Timeout pulse not at the limit second.");

    property p_first_after_block;
        first_result |-> result_pulse && sec_cnt == 10'(status_flags_pkg::FIRST_BLOCK_SEC);
    endproperty
    a_first_after_block: assert property (p_first_after_block)
        else $error("First result not at the end of the accumulation block.");

    property p_no_result_when_stopped;
        !run_active |=> !result_pulse && !timeout_pulse;
    endproperty
    a_no_result_when_stopped: assert property (p_no_result_when_stopped)
        else $error("Result or timeout pulse after the run stopped.");

endmodule

/* core/metering_status_flags.sv */
// Status flag bank: autocalibration flags, live event levels, chip error flags, read-only register port.
// Assumes all condition inputs come from logic on core_clk; soft_rst comes from the software reset decode.
//
// Functional notes
// - Autocalibration timeout flag sets when a run reaches 600 seconds unfinished.
// - Result-ready flag first sets when results appear after the 8-second block.
// - Result-ready flag sets again each second on result update until the run stops or times out.
// - Coefficient-shift flag sets when the coefficient changes partway through a run.
// - Overcurrent bits 5 and 4 follow channels B and A live.
// - Swell bit reads one during swell and zero once it ends.
// - Dip bit reads one during dip and zero once it ends.
// - Serial reset flag sets when a serial interface reset is detected.
// - Serial fault flags hold until the serial interface is reset or a hardware reset.
// - Internal fault flags hold until a software or hardware reset.
`timescale 1ns/10ps
module metering_status_flags #(
    parameter int CYCLES_PER_SEC = status_flags_pkg::CYCLES_PER_SEC, // Clock cycles in one second.
    parameter int COEF_WIDTH     = 32                                // Width of the coefficient.
) (
    input  wire logic                                   core_clk,                // Core clock, 100 MHz.
    input  wire logic                                   sys_rst,                 // Synchronous reset, active high.
    input  wire logic                                   soft_rst,                // Software reset pulse.
    input  wire logic                                   autocal_run,             // Autocalibration enabled.
    input  wire logic [COEF_WIDTH-1:0]                  calibration_coefficient, // Coefficient found.
    input  wire status_flags_pkg::event_levels_type     event_levels,            // Live metering conditions.
    input  wire logic                                   serial_reset_seen,       // Serial reset detected, pulse.
    input  wire status_flags_pkg::serial_faults_type    serial_faults,           // Serial fault events.
    input  wire status_flags_pkg::internal_faults_type  internal_faults,         // Internal fault events.
    input  wire logic [15:0]                            reg_addr,                // Register address.
    input  wire logic                                   reg_rd,                  // Read strobe, one cycle.
    input  wire logic                                   reg_wr,                  // Write strobe, ignored.
    input  wire logic [15:0]                            reg_wdata,               // Write data, ignored.
    output logic [15:0]                                 reg_rdata,               // Read data, registered.
    output logic                                        reg_rvalid               // Read data valid pulse.
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Run timer.
    logic result_pulse;
    logic timeout_pulse;
    logic first_result;

    autocal_timer #(
        .CYCLES_PER_SEC (CYCLES_PER_SEC)
    ) timer (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .run_active    (autocal_run),
        .result_pulse  (result_pulse),
        .timeout_pulse (timeout_pulse),
        .first_result  (first_result)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Address decode and read-side clears.
    wire hit_autocal  = (reg_addr == status_flags_pkg::AUTOCAL_STATUS_ADDR);
    wire hit_event    = (reg_addr == status_flags_pkg::EVENT_LEVELS_ADDR);
    wire hit_chip     = (reg_addr == status_flags_pkg::CHIP_ERROR_ADDR);
    wire clr_autocal  = reg_rd && hit_autocal;
    wire clr_chip     = reg_rd && hit_chip;

    // Coefficient shift: a later result carries a value different from the one captured before.
    logic [COEF_WIDTH-1:0] last_coef;
    logic                  have_coef;
    wire                   coef_moved = result_pulse && have_coef && !first_result &&
                                        (calibration_coefficient != last_coef);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Autocalibration flags; a set in the cycle of a clearing read wins, so no event is lost.
    logic autocal_timeout_flag;
    logic autocal_result_ready_flag;
    logic coefficient_shift_flag;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            autocal_timeout_flag      <= 1'b0;
            autocal_result_ready_flag <= 1'b0;
            coefficient_shift_flag    <= 1'b0;
        end
        else
        begin
            autocal_timeout_flag      <= timeout_pulse || (autocal_timeout_flag && !clr_autocal);
            autocal_result_ready_flag <= result_pulse || (autocal_result_ready_flag && !clr_autocal);
            coefficient_shift_flag    <= coef_moved || (coefficient_shift_flag && !clr_autocal);
        end
    end

    // Coefficient capture on every result; a stopped run forgets it so the next run starts clean.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !autocal_run)
        begin
            last_coef <= '0;
            have_coef <= 1'b0;
        end
        else if (result_pulse)
        begin
            last_coef <= calibration_coefficient;
            have_coef <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Chip error flags. Serial faults clear only on a serial or hardware reset; internal faults only on a reset.
    logic                                  serial_reset_flag;
    status_flags_pkg::serial_faults_type   serial_fault_flags;
    status_flags_pkg::internal_faults_type internal_fault_flags;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            serial_reset_flag    <= 1'b0;
            serial_fault_flags   <= '0;
            internal_fault_flags <= '0;
        end
        else
        begin
            serial_reset_flag    <= serial_reset_seen || (serial_reset_flag && !clr_chip);
            serial_fault_flags   <= serial_faults | (serial_reset_seen ? '0 : serial_fault_flags);
            internal_fault_flags <= internal_faults | (soft_rst ? '0 : internal_fault_flags);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Register images; every bit not placed below is reserved and reads zero.
    logic [15:0] autocal_image;
    logic [15:0] event_image;
    logic [15:0] chip_image;

    always_comb
    begin
        autocal_image = status_flags_pkg::REG_RESET_VALUE;
        event_image   = status_flags_pkg::REG_RESET_VALUE;
        chip_image    = status_flags_pkg::REG_RESET_VALUE;
        autocal_image[status_flags_pkg::AUTOCAL_TIMEOUT_BIT] = autocal_timeout_flag;
        autocal_image[status_flags_pkg::AUTOCAL_READY_BIT]   = autocal_result_ready_flag;
        autocal_image[status_flags_pkg::COEF_SHIFT_BIT]      = coefficient_shift_flag;
        event_image[status_flags_pkg::OVERCURRENT_B_BIT] = event_levels.overcurrent_chan_b;
        event_image[status_flags_pkg::OVERCURRENT_A_BIT] = event_levels.overcurrent_chan_a;
        event_image[status_flags_pkg::SWELL_BIT]         = event_levels.voltage_swell_level;
        event_image[status_flags_pkg::DIP_BIT]           = event_levels.voltage_dip_level;
        chip_image[status_flags_pkg::SERIAL_RESET_BIT]   = serial_reset_flag;
        chip_image[status_flags_pkg::SERIAL_FAULT_LSB +: 3]   = serial_fault_flags;
        chip_image[status_flags_pkg::INTERNAL_FAULT_LSB +: 4] = internal_fault_flags;
    end

    // Read select; unmapped addresses answer zero. Writes have no path into any flag.
    wire [15:0] read_select = hit_autocal ? autocal_image :
                              hit_event   ? event_image   :
                              hit_chip    ? chip_image    : status_flags_pkg::REG_RESET_VALUE;

    // Read data is captured on the strobe edge, which also applies the read-side clears above.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            reg_rdata  <= status_flags_pkg::REG_RESET_VALUE;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                reg_rdata <= read_select;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks tying flags and read data to their causes.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_timeout_sets;
        timeout_pulse |=> autocal_timeout_flag;
    endproperty
    a_timeout_sets: assert property (p_timeout_sets)
        else $error("Timeout flag not set after timeout.");

    property p_ready_sets;
        result_pulse |=> autocal_result_ready_flag;
    endproperty
    a_ready_sets: assert property (p_ready_sets)
        else $error("Result-ready flag not set after a result.");

    // A set flag must survive until the clearing read and show up in the data that read returns.
    property p_ready_read_back;
        autocal_result_ready_flag && clr_autocal |=> reg_rvalid && reg_rdata[status_flags_pkg::AUTOCAL_READY_BIT];
    endproperty
    a_ready_read_back: assert property (p_ready_read_back)
        else $error("Result-ready flag lost before the read.");

    property p_shift_sets;
        coef_moved |=> coefficient_shift_flag;
    endproperty
    a_shift_sets: assert property (p_shift_sets)
        else $error("Coefficient shift not flagged.");

    property p_overcurrent_live;
        reg_rd && hit_event |=> reg_rdata[5:4] == {$past(event_levels.overcurrent_chan_b),
                                                   $past(event_levels.overcurrent_chan_a)};
    endproperty
    a_overcurrent_live: assert property (p_overcurrent_live)
        else $error("Overcurrent bits do not follow the channels.");

    property p_swell_dip_live;
        reg_rd && hit_event |=> reg_rdata[2] == $past(event_levels.voltage_swell_level) &&
                                reg_rdata[0] == $past(event_levels.voltage_dip_level) && reg_rdata[15:6] == 10'h000;
    endproperty
    a_swell_dip_live: assert property (p_swell_dip_live)
        else $error("Swell or dip bit does not follow the voltage channel.");

    property p_serial_reset_sets;
        serial_reset_seen |=> serial_reset_flag && serial_fault_flags == $past(serial_faults);
    endproperty
    a_serial_reset_sets: assert property (p_serial_reset_sets)
        else $error("Serial reset not flagged or faults not cleared.");

    property p_serial_fault_holds;
        (|serial_fault_flags) && !serial_reset_seen |=> (serial_fault_flags & $past(serial_fault_flags)) ==
                                                        $past(serial_fault_flags);
    endproperty
    a_serial_fault_holds: assert property (p_serial_fault_holds)
        else $error("Serial fault flag dropped without a serial reset.");

    property p_internal_fault_holds;
        (|internal_fault_flags) && !soft_rst |=> (internal_fault_flags & $past(internal_fault_flags)) ==
                                                 $past(internal_fault_flags);
    endproperty
    a_internal_fault_holds: assert property (p_internal_fault_holds)
        else $error("Internal fault flag dropped without a reset.");

    property p_unmapped_zero;
        reg_rd && !hit_autocal && !hit_event && !hit_chip |=> reg_rvalid && reg_rdata == 16'h0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("Unmapped address returned nonzero data.");

    property p_write_ignored;
        reg_wr && !reg_rd && !timeout_pulse && !result_pulse && !serial_reset_seen && !soft_rst
            && !(|serial_faults) && !(|internal_faults) |=> $stable(autocal_image) && $stable(chip_image)
            && $stable(reg_rdata);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("A write changed a status register.");

    c_timeout: cover property (timeout_pulse);
    c_shift: cover property (coef_moved);
    c_chip_read: cover property (reg_rd && hit_chip && (|internal_fault_flags));
    c_set_on_clear: cover property (clr_autocal && result_pulse);

endmodule

/* verification/status_host_model.sv */
// Host model: the processor that reads and writes the status flag bank's register port.
// Assumes one call at a time from code that runs on core_clk; inputs change 1 ns after the edge.
`timescale 1ns/10ps
module status_host_model (
    input  wire logic        core_clk,   // Core clock.
    output logic [15:0]      reg_addr,   // Register address.
    output logic             reg_rd,     // Read strobe.
    output logic             reg_wr,     // Write strobe.
    output logic [15:0]      reg_wdata,  // Write data.
    input  wire logic [15:0] reg_rdata,  // Read data.
    input  wire logic        reg_rvalid  // Read data valid.
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero.
    initial
    begin
        reg_addr  = 16'hffff;
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // One-cycle strobe; data is taken in the cycle after, while reg_rvalid stands.
    task automatic read(input logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a; // A released bus must not look like the last address.
        d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    endtask

    // Writes are offered the same way, although the bank must drop them.
    task automatic write(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
endmodule

/* verification/test_metering_status_flags.sv */
// Testbench: register reads of the status flag bank against values worked out from its rules.
// Assumes status_flags_pkg is compiled first; one second is shortened to SEC clock cycles.
`timescale 1ns/10ps
module test_metering_status_flags;
    localparam int SEC = 40;

    logic                                  core_clk = 1'b0;
    logic                                  sys_rst  = 1'b1;
    logic                                  soft_rst = 1'b0;
    logic                                  autocal_run = 1'b0;
    logic [31:0]                           coef = 32'h0000_0005;
    status_flags_pkg::event_levels_type    event_levels = '0;
    logic                                  serial_reset_seen = 1'b0;
    status_flags_pkg::serial_faults_type   serial_faults = '0;
    status_flags_pkg::internal_faults_type internal_faults = '0;
    logic [15:0]                           reg_addr;
    logic                                  reg_rd;
    logic                                  reg_wr;
    logic [15:0]                           reg_wdata;
    logic [15:0]                           reg_rdata;
    logic                                  reg_rvalid;
    logic [15:0]                           d;
    int                                    n_errors = 0;
    int                                    checks = 0;
    int                                    cyc = 0;
    int                                    t0;
    logic [15:0]                           ev_exp [4] = '{16'h0001, 16'h0004, 16'h0010, 16'h0020};

    metering_status_flags #(.CYCLES_PER_SEC(SEC), .COEF_WIDTH(32)) metering_status_flags_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .soft_rst(soft_rst), .autocal_run(autocal_run),
        .calibration_coefficient(coef), .event_levels(event_levels), .serial_reset_seen(serial_reset_seen),
        .serial_faults(serial_faults), .internal_faults(internal_faults), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    status_host_model status_host_model_i (
        .core_clk(core_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, cycle count and watchdog; the autocal timeout run alone needs about 24,100 cycles.
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    initial
    begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        summarize();
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t: read %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        status_host_model_i.read(a, d);
        check(d, exp);
    endtask

    // Waiting on an absolute cycle keeps autocal reads mid-second however long each read took.
    task automatic wait_until(input int t);
        while (cyc < t) @(posedge core_clk);
    endtask

    task automatic summarize();
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (12) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        // Reset values, dropped writes, unmapped address.
        for (int a = 0; a < 3; a++)
        begin
            status_host_model_i.write(16'h04c0 + 16'(a), 16'hffff);
            rd_chk(16'h04c0 + 16'(a), 16'h0000);
        end
        event_levels = 4'hf;
        rd_chk(16'h04c3, 16'h0000);
        rd_chk(16'h04c1, 16'h0035);
        // Each live level alone, then all gone.
        for (int i = 0; i < 4; i++)
        begin
            event_levels = 4'(1 << i);
            rd_chk(16'h04c1, ev_exp[i]);
        end
        event_levels = 4'h0;
        rd_chk(16'h04c1, 16'h0000);
        // Chip errors: set, serial reset, clear on read, software reset, hardware reset.
        @(posedge core_clk);
        #1 serial_faults = 3'b111;
        internal_faults = 4'hf;
        @(posedge core_clk);
        #1 serial_faults = 3'b000;
        internal_faults = 4'h0;
        rd_chk(16'h04c2, 16'h007f);
        rd_chk(16'h04c2, 16'h007f);
        serial_reset_seen = 1'b1;
        @(posedge core_clk);
        #1 serial_reset_seen = 1'b0;
        rd_chk(16'h04c2, 16'h008f);
        rd_chk(16'h04c2, 16'h000f);
        soft_rst = 1'b1;
        @(posedge core_clk);
        #1 soft_rst = 1'b0;
        internal_faults = 4'h5;
        @(posedge core_clk);
        #1 internal_faults = 4'h0;
        rd_chk(16'h04c2, 16'h0005);
        sys_rst = 1'b1;
        @(posedge core_clk);
        #1 sys_rst = 1'b0;
        rd_chk(16'h04c2, 16'h0000);
        // Autocal run: nothing before 8 s, then a result each second, then a coefficient shift.
        @(posedge core_clk);
        #1 autocal_run = 1'b1;
        t0 = cyc;
        wait_until(t0 + 7 * SEC + SEC / 2);
        rd_chk(16'h04c0, 16'h0000);
        wait_until(t0 + 8 * SEC + SEC / 2);
        rd_chk(16'h04c0, 16'h0002);
        wait_until(t0 + 9 * SEC + SEC / 2);
        rd_chk(16'h04c0, 16'h0002);
        coef = 32'h0000_0006;
        wait_until(t0 + 10 * SEC + SEC / 2);
        rd_chk(16'h04c0, 16'h0003);
        // Shift seen: rerun with the same settings, this time up to the timeout.
        autocal_run = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 autocal_run = 1'b1;
        t0 = cyc;
        wait_until(t0 + 598 * SEC + SEC / 2);
        rd_chk(16'h04c0, 16'h0002);
        wait_until(t0 + 600 * SEC + SEC / 2);
        rd_chk(16'h04c0, 16'h000a);
        wait_until(t0 + 602 * SEC + SEC / 2);
        rd_chk(16'h04c0, 16'h0000);
        #1 autocal_run = 1'b0;
        summarize();
    end
endmodule
